// *** shared/sid_pkg.sv ***
`default_nettype none
package sid_pkg;
   // ==========================================================
   // clock and timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int PULSE_HIGH_NS  = 1000;
   localparam int PULSE_LOW_NS   = 1000;
   localparam int DIR_GAP_NS     = 5000;
   localparam int BRAKE_DELAY_NS = 20000;

   // ns rounded up to cycles, at least one
   function automatic int sid_ns_to_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : sid_ns_to_cycles

   localparam int PULSE_HIGH_CYC  = sid_ns_to_cycles(PULSE_HIGH_NS);
   localparam int PULSE_LOW_CYC   = sid_ns_to_cycles(PULSE_LOW_NS);
   localparam int DIR_GAP_CYC     = sid_ns_to_cycles(DIR_GAP_NS);
   localparam int BRAKE_DELAY_CYC = sid_ns_to_cycles(BRAKE_DELAY_NS);
   localparam int TIMER_W         = 16;

   // ==========================================================
   // link lines, index in the synchroniser vector
   localparam int LINK_W      = 5;
   localparam int LN_CW       = 0;
   localparam int LN_CCW      = 1;
   localparam int LN_EXCITE   = 2;
   localparam int LN_RELEASE  = 3;
   localparam int LN_DUAL_SEL = 4;

   // ==========================================================
   // controller registers (byte addresses)
   localparam int ADR_W         = 4;
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_MOVE   = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   // control fields
   localparam int CTRL_EXCITE   = 0;
   localparam int CTRL_RELEASE  = 1;
   localparam int CTRL_DUAL_SEL = 2;
   localparam int CTRL_DUAL     = 3;
   localparam int CTRL_BRAKE    = 4;
   localparam int CTRL_W        = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // move fields
   localparam int MOVE_CNT_W    = 16;
   localparam int MOVE_DIR      = 16;
   // status fields
   localparam int STAT_BUSY     = 0;
   localparam int STAT_BRAKE    = 1;
   localparam int POS_W         = 32;
endpackage : sid_pkg
`default_nettype wire

// *** shared/sid_link_if.sv ***
`default_nettype none
interface sid_link_if;
   // each line is high while its optocoupler conducts
   logic clockwise_pulse;
   logic counterclockwise_pulse;
   logic excite_en;
   logic shaft_release;
   logic dual_sel;

   modport controller (
      output clockwise_pulse,
      output counterclockwise_pulse,
      output excite_en,
      output shaft_release,
      output dual_sel
   );
   modport device (
      input clockwise_pulse,
      input counterclockwise_pulse,
      input excite_en,
      input shaft_release,
      input dual_sel
   );
endinterface : sid_link_if
`default_nettype wire

// *** src/sid_sync.sv ***
`default_nettype none
module sid_sync (
   input  wire logic                     ref_clk,
   input  wire logic                     sys_rst,
   input  wire logic [sid_pkg::LINK_W-1:0] din,
   output logic      [sid_pkg::LINK_W-1:0] level,
   output logic      [sid_pkg::LINK_W-1:0] rise,
   output logic      [sid_pkg::LINK_W-1:0] fall
);
   import sid_pkg::*;

   logic [LINK_W-1:0] meta_reg;
   logic [LINK_W-1:0] sync_reg;
   logic [LINK_W-1:0] last_reg;

   // ==========================================================
   // two-flop synchroniser
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // edges seen on the settled copy only
   assign level = sync_reg;
   assign rise  = sync_reg & ~last_reg;
   assign fall  = ~sync_reg & last_reg;
endmodule : sid_sync
`default_nettype wire

// *** src/sid_device.sv ***
`default_nettype none
// Summary of operation
// R1 - line active means optocoupler conducts
// R2 - excitation enable energizes motor windings
// R3 - excitation polarity normally open, optionally closed
// R4 - controller frees brake only after excitation
// R5 - pins: cw/ccw dual, step/sense single
// R6 - single: step with sense active goes cw
// R7 - single: step with sense inactive goes ccw
// R8 - dual: each pin steps its own way
// R9 - dual: both pins active counts nothing
// R10 - controller keeps other pulse pin inactive
// R11 - controller idles pulse pins non-conducting
// R12 - controller leaves gap before reversing sense
// R13 - release cuts current, frees AC brake
// R14 - release inactive restores current and torque
// R15 - no brake: hold only enabled, unreleased
// R16 - AC brake holds when both inactive
// R17 - DC units: release never touches brake
// R18 - return after release is optional
// R19 - shared pin: resolution or push current
// R20 - push select active gives push current
// R21 - fixed alternate resolution ignores select pin
// R22 - synchronize inputs, one step per rise
module sid_device (
   input  wire logic                      ref_clk,
   input  wire logic                      sys_rst,
   sid_link_if.device                     link,
   input  wire logic                      cfg_dual_pulse,
   input  wire logic                      cfg_excite_nc,
   input  wire logic                      cfg_ac_power,
   input  wire logic                      cfg_brake_fitted,
   input  wire logic                      cfg_auto_return,
   input  wire logic                      cfg_push_mode,
   input  wire logic                      cfg_fixed_alt_res,
   output logic                           step_cw,
   output logic                           step_ccw,
   output logic                           pulse_conflict,
   output logic signed [sid_pkg::POS_W-1:0] position,
   output logic                           windings_on,
   output logic                           brake_hold,
   output logic                           auto_return_req,
   output logic                           res_alt_sel,
   output logic                           push_current_on
);
   import sid_pkg::*;

   // ==========================================================
   // synchronised link lines
   logic [LINK_W-1:0] raw_lines;
   logic [LINK_W-1:0] lvl;
   logic [LINK_W-1:0] rise;
   logic [LINK_W-1:0] fall;

   // raw lines are conduction states, not voltage levels
   assign raw_lines[LN_CW]       = link.clockwise_pulse; // R1
   assign raw_lines[LN_CCW]      = link.counterclockwise_pulse;
   assign raw_lines[LN_EXCITE]   = link.excite_en;
   assign raw_lines[LN_RELEASE]  = link.shaft_release;
   assign raw_lines[LN_DUAL_SEL] = link.dual_sel;

   // every line passes two flops before any logic
   sid_sync u_sync ( // R22
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .din     (raw_lines),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   // ==========================================================
   // step decode
   logic cw_next;
   logic ccw_next;
   logic conflict_next;
   logic excite_act;
   logic release_act;

   // pin roles depend on the pulse mode
   always_comb begin // R5
      cw_next       = 1'b0;
      ccw_next      = 1'b0;
      conflict_next = 1'b0;
      if (cfg_dual_pulse) begin
         // both lines active together: no step at all
         if (lvl[LN_CW] && lvl[LN_CCW]) begin
            conflict_next = rise[LN_CW] | rise[LN_CCW]; // R9
         end else begin
            cw_next  = rise[LN_CW]; // R8
            ccw_next = rise[LN_CCW]; // R8
         end
      end else if (rise[LN_CW]) begin
         // second pin is the rotation sense level
         if (lvl[LN_CCW]) begin
            cw_next = 1'b1; // R6
         end else begin
            ccw_next = 1'b1; // R7
         end
      end
   end

   // one-cycle step strobes, one per detected rise
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         step_cw        <= 1'b0;
         step_ccw       <= 1'b0;
         pulse_conflict <= 1'b0;
      end else begin
         step_cw        <= cw_next; // R22
         step_ccw       <= ccw_next; // R22
         pulse_conflict <= conflict_next;
      end
   end

   // command position, cw counts up
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         position <= '0;
      end else if (cw_next) begin
         position <= position + POS_W'(1);
      end else if (ccw_next) begin
         position <= position - POS_W'(1);
      end
   end

   // ==========================================================
   // excitation, release and brake
   // normally closed logic enables while the line is idle
   assign excite_act  = cfg_excite_nc ? ~lvl[LN_EXCITE]
                                      : lvl[LN_EXCITE]; // R3
   assign release_act = lvl[LN_RELEASE];

   // windings energized only when enabled and not released
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         windings_on <= 1'b0;
      end else begin
         windings_on <= excite_act & ~release_act; // R2 R13 R14 R15
      end
   end

   // brake drive exists only on AC units with a brake fitted
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         brake_hold <= 1'b0;
      end else if (cfg_ac_power && cfg_brake_fitted) begin
         // release active always frees the shaft
         brake_hold <= ~excite_act & ~release_act; // R16 R13
      end else begin
         // dc units or no brake fitted: brake follows its own supply only
         brake_hold <= 1'b0; // R17
      end
   end

   // optional return request as release goes inactive
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         auto_return_req <= 1'b0;
      end else begin
         auto_return_req <= cfg_auto_return & fall[LN_RELEASE]; // R18
      end
   end

   // ==========================================================
   // shared resolution / push current pin
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         res_alt_sel     <= 1'b0;
         push_current_on <= 1'b0;
      end else begin
         // pin is push select in push mode, else resolution
         push_current_on <= cfg_push_mode & lvl[LN_DUAL_SEL]; // R19 R20
         if (cfg_fixed_alt_res) begin
            res_alt_sel <= 1'b1; // R21
         end else begin
            res_alt_sel <= ~cfg_push_mode & lvl[LN_DUAL_SEL]; // R19
         end
      end
   end
endmodule : sid_device
`default_nettype wire

// *** src/sid_controller.sv ***
`default_nettype none
module sid_controller (
   input  wire logic                      ref_clk,
   input  wire logic                      sys_rst,
   sid_link_if.controller                 link,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [sid_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   output logic                           brake_release
);
   import sid_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_GAP   = 4'b0010,
      ST_HIGH  = 4'b0100,
      ST_LOW   = 4'b1000
   } sid_state_e;

   sid_state_e              state_reg;
   logic [CTRL_W-1:0]       ctrl_reg;
   logic [MOVE_CNT_W-1:0]   remain_reg;
   logic                    dir_reg;
   logic [TIMER_W-1:0]      timer_reg;
   logic [TIMER_W-1:0]      brake_tmr_reg;
   logic                    wr_stb;
   logic                    start;
   logic                    dir_cmd;

   // ==========================================================
   // wishbone slave, ack one cycle after request
   assign wr_stb  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign start   = wr_stb & (wb_adr_i == OFS_MOVE) & (&wb_sel_i[2:0])
                    & (state_reg == ST_IDLE)
                    & (wb_dat_i[MOVE_CNT_W-1:0] != '0);
   assign dir_cmd = wb_dat_i[MOVE_DIR];

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // read data, unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wb_dat_o <= '0;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         case (wb_adr_i)
            OFS_CTRL:   wb_dat_o <= 32'(ctrl_reg);
            OFS_MOVE:   wb_dat_o <= {15'h0000, dir_reg, remain_reg};
            OFS_STATUS: wb_dat_o <= {30'h00000000, brake_release,
                                     state_reg != ST_IDLE};
            default:    wb_dat_o <= '0;
         endcase
      end
   end

   // control register, byte lane 0
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_stb && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
         ctrl_reg <= wb_dat_i[CTRL_W-1:0];
      end
   end

   // ==========================================================
   // step pulse sequencer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg  <= ST_IDLE;
         remain_reg <= '0;
         dir_reg    <= 1'b1;
         timer_reg  <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  remain_reg <= wb_dat_i[MOVE_CNT_W-1:0];
                  dir_reg    <= dir_cmd;
                  // longer pause when the sense reverses
                  timer_reg  <= (dir_cmd != dir_reg)
                                ? TIMER_W'(DIR_GAP_CYC)
                                : TIMER_W'(PULSE_LOW_CYC); // R12
                  state_reg  <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (timer_reg <= TIMER_W'(1)) begin
                  timer_reg <= TIMER_W'(PULSE_HIGH_CYC);
                  state_reg <= ST_HIGH;
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            ST_HIGH: begin
               if (timer_reg <= TIMER_W'(1)) begin
                  timer_reg  <= TIMER_W'(PULSE_LOW_CYC);
                  remain_reg <= remain_reg - MOVE_CNT_W'(1);
                  state_reg  <= ST_LOW;
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            ST_LOW: begin
               if (timer_reg > TIMER_W'(1)) begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end else if (remain_reg != '0) begin
                  timer_reg <= TIMER_W'(PULSE_HIGH_CYC);
                  state_reg <= ST_HIGH;
               end else begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // link drive; step pulses idle non-conducting, in single mode the ccw line holds the sense level
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         link.clockwise_pulse        <= 1'b0;
         link.counterclockwise_pulse <= 1'b0;
         link.excite_en              <= 1'b0;
         link.shaft_release          <= 1'b0;
         link.dual_sel               <= 1'b0;
      end else begin
         link.excite_en     <= ctrl_reg[CTRL_EXCITE];
         link.shaft_release <= ctrl_reg[CTRL_RELEASE];
         link.dual_sel      <= ctrl_reg[CTRL_DUAL_SEL];
         if (ctrl_reg[CTRL_DUAL]) begin
            // only the line of the chosen sense ever pulses
            link.clockwise_pulse <= (state_reg == ST_HIGH)
                                    & dir_reg; // R10 R11
            link.counterclockwise_pulse <= (state_reg == ST_HIGH)
                                           & ~dir_reg; // R10 R11
         end else begin
            // sense level steady, step line pulses
            link.clockwise_pulse        <= (state_reg == ST_HIGH); // R11
            link.counterclockwise_pulse <= dir_reg;
         end
      end
   end

   // brake freed only after excitation has been commanded
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         brake_tmr_reg <= '0;
         brake_release <= 1'b0;
      end else if (!ctrl_reg[CTRL_EXCITE] || ctrl_reg[CTRL_RELEASE]) begin
         brake_tmr_reg <= '0;
         brake_release <= 1'b0;
      end else if (brake_tmr_reg < TIMER_W'(BRAKE_DELAY_CYC)) begin
         brake_tmr_reg <= brake_tmr_reg + TIMER_W'(1);
         brake_release <= 1'b0;
      end else begin
         brake_release <= ctrl_reg[CTRL_BRAKE]; // R4
      end
   end
endmodule : sid_controller
`default_nettype wire

// *** bench/sid_asserts.sv ***
`default_nettype none
module sid_asserts (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clockwise_pulse,
   input wire logic counterclockwise_pulse,
   input wire logic excite_en,
   input wire logic shaft_release,
   input wire logic dual_sel,
   input wire logic cfg_dual_pulse,
   input wire logic cfg_excite_nc,
   input wire logic cfg_ac_power,
   input wire logic cfg_brake_fitted,
   input wire logic cfg_auto_return,
   input wire logic cfg_push_mode,
   input wire logic cfg_fixed_alt_res,
   input wire logic step_cw,
   input wire logic step_ccw,
   input wire logic windings_on,
   input wire logic brake_hold,
   input wire logic auto_return_req,
   input wire logic res_alt_sel,
   input wire logic push_current_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========================================================
   // excitation after polarity, shared clocking
   logic ex_act;
   assign ex_act = excite_en ^ cfg_excite_nc;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // ========================================================
   // step decoding
   property p_cw_dual;
      cfg_dual_pulse && $rose(clockwise_pulse) && !counterclockwise_pulse
         |-> ##[1:4] step_cw;
   endproperty
   a_cw_dual: assert property (p_cw_dual)
      else $error("no cw step");
   property p_ccw_dual;
      cfg_dual_pulse && $rose(counterclockwise_pulse) && !clockwise_pulse
         |-> ##[1:4] step_ccw;
   endproperty
   a_ccw_dual: assert property (p_ccw_dual)
      else $error("no ccw step");
   property p_single;
      !cfg_dual_pulse && $rose(clockwise_pulse) |-> ##[1:4]
         (counterclockwise_pulse ? step_cw : step_ccw);
   endproperty
   a_single: assert property (p_single)
      else $error("wrong single step");
   property p_excl;
      cfg_dual_pulse && $rose(clockwise_pulse) |-> !counterclockwise_pulse;
   endproperty
   a_excl: assert property (p_excl)
      else $error("both pulse lines high");

   // ========================================================
   // shaft holding and brake
   property p_hold;
      (ex_act && !shaft_release)[*5] |-> windings_on;
   endproperty
   a_hold: assert property (p_hold)
      else $error("windings off");
   property p_free;
      shaft_release[*5] |-> !windings_on && !brake_hold;
   endproperty
   a_free: assert property (p_free)
      else $error("shaft not freed");
   property p_brake_ac;
      (cfg_ac_power && cfg_brake_fitted && !ex_act && !shaft_release)[*5]
         |-> brake_hold && !windings_on;
   endproperty
   a_brake_ac: assert property (p_brake_ac)
      else $error("brake not holding");
   property p_brake_dc;
      (!(cfg_ac_power && cfg_brake_fitted))[*3] |-> !brake_hold;
   endproperty
   a_brake_dc: assert property (p_brake_dc)
      else $error("brake without ac brake");
   property p_auto;
      cfg_auto_return && $fell(shaft_release) |-> ##[1:4] auto_return_req;
   endproperty
   a_auto: assert property (p_auto)
      else $error("no return request");

   // ========================================================
   // dual purpose pin
   property p_push;
      (cfg_push_mode && dual_sel)[*5]
         |-> push_current_on && (res_alt_sel == cfg_fixed_alt_res);
   endproperty
   a_push: assert property (p_push)
      else $error("no push current");
   property p_fixed;
      cfg_fixed_alt_res[*3] |-> res_alt_sel;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed resolution not kept");

   c_cw: cover property (step_cw);
   c_ccw: cover property (step_ccw);
   c_brake: cover property (brake_hold);
   c_ret: cover property (auto_return_req);
endmodule : sid_asserts
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sid_pkg::*;
   // ========================================================
   // signals
   logic        ref_clk = 1'b0;
   logic        sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, brake_release;
   logic [3:0]  wb_adr, wb_sel;
   logic [31:0] wb_dat, wb_dat_o, rd;
   logic        cfg_dual_pulse, cfg_excite_nc, cfg_ac_power, ex;
   logic        cfg_brake_fitted, cfg_auto_return, cfg_push_mode;
   logic        cfg_fixed_alt_res, d2_dual, s2_cw, s2_ccw, s2_conf;
   logic        step_cw, step_ccw, windings_on, brake_hold;
   logic        auto_return_req, res_alt_sel, push_current_on;
   logic signed [POS_W-1:0] position;
   int          mismatches = 0;
   int          total_checks = 0;
   int          pos_m = 0, n2_cw = 0, n2_ccw = 0, n2_conf = 0, n_ret = 0, k;
   sid_link_if  link1 ();
   sid_link_if  link2 ();

   // ========================================================
   // two ends joined, second device driven by the bench
   sid_controller sid_controller_i (.ref_clk, .sys_rst, .link(link1),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o, .wb_ack_o(wb_ack), .brake_release);
   sid_device sid_device_i (.ref_clk, .sys_rst, .link(link1),
      .cfg_dual_pulse, .cfg_excite_nc, .cfg_ac_power, .cfg_brake_fitted,
      .cfg_auto_return, .cfg_push_mode, .cfg_fixed_alt_res, .step_cw,
      .step_ccw, .pulse_conflict(), .position, .windings_on, .brake_hold,
      .auto_return_req, .res_alt_sel, .push_current_on);
   sid_device sid_device_i2 (.ref_clk, .sys_rst, .link(link2),
      .cfg_dual_pulse(d2_dual), .cfg_excite_nc, .cfg_ac_power,
      .cfg_brake_fitted, .cfg_auto_return, .cfg_push_mode,
      .cfg_fixed_alt_res, .step_cw(s2_cw), .step_ccw(s2_ccw),
      .pulse_conflict(s2_conf), .position(), .windings_on(), .brake_hold(),
      .auto_return_req(), .res_alt_sel(), .push_current_on());
   sid_asserts sid_asserts_i (.ref_clk, .sys_rst,
      .clockwise_pulse(link1.clockwise_pulse),
      .counterclockwise_pulse(link1.counterclockwise_pulse),
      .excite_en(link1.excite_en), .shaft_release(link1.shaft_release),
      .dual_sel(link1.dual_sel), .cfg_dual_pulse, .cfg_excite_nc,
      .cfg_ac_power, .cfg_brake_fitted, .cfg_auto_return, .cfg_push_mode,
      .cfg_fixed_alt_res, .step_cw, .step_ccw, .windings_on, .brake_hold,
      .auto_return_req, .res_alt_sel, .push_current_on);

   // clock, watchdog, step and return request counters
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      timeout_hit();
   end
   always_ff @(posedge ref_clk) begin
      n2_cw <= n2_cw + int'(s2_cw === 1'b1);
      n2_ccw <= n2_ccw + int'(s2_ccw === 1'b1);
      n2_conf <= n2_conf + int'(s2_conf === 1'b1);
      n_ret <= n_ret + int'(auto_return_req === 1'b1);
   end

   // ========================================================
   // reporting and compares
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic timeout_hit;
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      conclude();
   endtask : timeout_hit
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_cnt(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         mismatches++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cnt

   // ========================================================
   // bus cycle, move and second-link driver
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, a, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) timeout_hit();
      q = wb_dat_o;
      {wb_cyc, wb_stb} <= 2'b00;
      @(posedge ref_clk);
   endtask : wb
   task automatic move(input int n, input logic cw);
      logic [31:0] q;
      int j;
      wb(1'b1, OFS_MOVE, {15'h0, cw, 16'(n)}, q);
      pos_m += cw ? n : -n;
      j = 0;
      do begin
         wb(1'b0, OFS_STATUS, 32'h0, q);
         j++;
      end while (q[STAT_BUSY] !== 1'b0 && j < 2000);
      if (j >= 2000) timeout_hit();
      repeat (6) @(posedge ref_clk);
      chk_val(position, pos_m);
   endtask : move
   task automatic drive2(input logic [1:0] cc);
      @(posedge ref_clk);
      {link2.clockwise_pulse, link2.counterclockwise_pulse} <= cc;
      repeat (6) @(posedge ref_clk);
   endtask : drive2

   // ========================================================
   // main sequence
   initial begin
      {sys_rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = {1'b1, 39'h0};
      wb_sel = 4'hF;
      {cfg_dual_pulse, cfg_excite_nc, cfg_ac_power, d2_dual} = 4'h0;
      {cfg_brake_fitted, cfg_auto_return} = 2'h0;
      {cfg_push_mode, cfg_fixed_alt_res} = 2'h0;
      {link2.excite_en, link2.shaft_release, link2.dual_sel} = 3'h0;
      {link2.clockwise_pulse, link2.counterclockwise_pulse} = 2'h0;
      void'($urandom(1));
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      wb(1'b0, OFS_CTRL, 32'h0, rd);
      chk_val(rd, {27'h0, CTRL_RESET});
      wb(1'b1, OFS_CTRL, 32'h1F, rd);
      wb(1'b0, OFS_CTRL, 32'h0, rd);
      chk_val(rd, 32'h1F);
      wb(1'b1, 4'hC, 32'hFFFFFFFF, rd);
      wb(1'b0, 4'hC, 32'h0, rd);
      chk_val(rd, 32'h0);
      wb(1'b1, OFS_MOVE, 32'h00010000, rd);
      wb(1'b0, OFS_STATUS, 32'h0, rd);
      chk_val(32'(rd[STAT_BUSY]), 32'h0);
      $display("registers test done");
      wb(1'b1, OFS_CTRL, 32'h1, rd);
      for (int i = 0; i < 8; i++) begin
         if (i == 4) begin
            cfg_dual_pulse <= 1'b1;
            wb(1'b1, OFS_CTRL, 32'h9, rd);
         end
         move(int'($urandom_range(3, 1)), 1'($urandom_range(1, 0)));
      end
      $display("move test done");
      for (int i = 0; i < 512; i++) begin
         {cfg_auto_return, cfg_fixed_alt_res, cfg_push_mode} <= 3'(i >> 6);
         {cfg_brake_fitted, cfg_ac_power, cfg_excite_nc} <= 3'(i >> 3);
         wb(1'b1, OFS_CTRL, {28'h0, 1'b1, 3'(i)}, rd);
         repeat (6) @(posedge ref_clk);
         ex = i[0] ^ i[3];
         chk_val(32'(windings_on), 32'(ex & !i[1]));
         chk_val(32'(brake_hold), 32'(i[4] & i[5] & !ex & !i[1]));
         chk_val(32'(res_alt_sel), 32'(i[7] | (!i[6] & i[2])));
         chk_val(32'(push_current_on), 32'(i[6] & i[2]));
      end
      chk_cnt(n_ret, 64);
      $display("level test done");
      {cfg_auto_return, cfg_fixed_alt_res, cfg_push_mode} <= 3'h0;
      {cfg_brake_fitted, cfg_ac_power, cfg_excite_nc} <= 3'h0;
      wb(1'b1, OFS_CTRL, 32'h19, rd);
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (brake_release !== 1'b1 && k < 2100);
      chk_cnt(int'(k > BRAKE_DELAY_CYC - 5 && k < BRAKE_DELAY_CYC + 5), 1);
      wb(1'b0, OFS_STATUS, 32'h0, rd);
      chk_val(32'(rd[STAT_BRAKE]), 32'h1);
      wb(1'b1, OFS_CTRL, 32'h1B, rd);
      @(posedge ref_clk);
      chk_val(32'(brake_release), 32'h0);
      $display("brake test done");
      drive2(2'b01);
      drive2(2'b11);
      drive2(2'b00);
      drive2(2'b10);
      drive2(2'b00);
      chk_cnt(n2_cw, 1);
      chk_cnt(n2_ccw, 1);
      d2_dual <= 1'b1;
      drive2(2'b10);
      drive2(2'b11);
      drive2(2'b01);
      drive2(2'b00);
      drive2(2'b01);
      drive2(2'b00);
      chk_cnt(n2_cw, 2);
      chk_cnt(n2_ccw, 2);
      chk_cnt(n2_conf, 1);
      $display("second link test done");
      conclude();
   end
endmodule : tb
`default_nettype wire
